// >>> pkg/csz_pkg.sv
// Package for the calibration status and zero-detect register bank.
package csz_pkg;
  localparam logic [7:0] ADDR_CAL_STATUS = 8'hDC;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hDD;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hDE;
  localparam int BIT_CAL_DONE = 0;
  localparam int BIT_TRIM_MOVED = 1;
  localparam int BIT_FLOOR_MOVED = 2;
  localparam int BIT_ZERO_HIT = 3;
  localparam int BIT_CAL_IRQ_EN = 1;
  localparam int BIT_CAL_IRQ_CLR = 1;
  localparam int ZERO_CNT_W = 5;
  localparam logic [4:0] ZERO_CNT_LIMIT = 5'h0F;
  localparam logic [4:0] ZERO_CNT_STEP_DOWN = 5'h01;
  localparam logic [7:0] RESET_CAL_STATUS = 8'h00;
  localparam logic [7:0] RESET_IRQ_ENABLE = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
endpackage

// >>> src/csz_calib_status.sv
// Calibration status flag bank with zero-reading detection and calibration interrupt.
//
// Behaviour
// R1 - Set zero-hit flag, bit 3, when zero readings exceed the weighting condition.
// R2 - Weight of zero never sets zero-hit flag nor raises its interrupt.
// R3 - Zero-hit flag stays set until software writes one; zero writes ignored.
// R4 - During calibration averaging, auto floor enabled sets baseline-moved flag, bit 2.
// R5 - In normal operation, lower floor sample replaces floor and sets baseline-moved.
// R6 - Both auto floor controls zero: baseline-moved never set, no interrupt.
// R7 - Baseline-moved cleared by writing one to it or to calibration clear bit.
// R8 - Automatic offset change sets offset-moved flag, bit 1.
// R9 - Both auto trim controls zero: offset-moved never set, no interrupt.
// R10 - Calibration completion sets calibration-done flag, bit 0.
// R11 - Offset-moved and calibration-done stay set until software writes one.
// R12 - Calibration interrupt asserts when any flag set and enable asserted.
// R13 - Software should recalibrate after seeing the zero-hit flag set.
// R14 - Internal zero-hit counter sets zero-hit flag on reaching 15.
// R15 - Each cycle counter adds weight if any channel zero, else subtracts one.
// R16 - Calibration interrupt enable is bit 1 of the enable register at 0xDD.
// R17 - Writing one to bit 1 at 0xDE clears pending calibration interrupt; code clears only baseline-moved, bit 2, so other set flags keep it asserted.
// R18 - Status bits 7 to 4 read as zero; writes to them ignored.
`timescale 1ns/1ps

module csz_calib_status #(
  parameter int FLOOR_W = 16 // Width of the proximity floor value.
) (
  input wire logic clk, // 200 MHz clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [7:0] reg_wdata, // Register write data.
  output logic [7:0] reg_rdata, // Register read data.
  input wire logic [3:0] zero_weight, // Zero detection weight.
  input wire logic prox_cycle, // One proximity/gesture cycle completed.
  input wire logic [3:0] chan_zero, // Per-channel conversion was zero.
  input wire logic avg_auto_floor, // Auto floor update during averaging.
  input wire logic prox_avg_auto_floor, // Auto floor update in proximity.
  input wire logic avg_auto_trim, // Auto offset adjust during averaging.
  input wire logic prox_auto_trim, // Auto offset adjust in proximity.
  input wire logic cal_avg_done, // Calibration DC averaging step done.
  input wire logic floor_sample_vld, // New floor sample available.
  input wire logic [FLOOR_W-1:0] prox_floor_sample, // Measured floor sample.
  input wire logic [FLOOR_W-1:0] cal_floor_value, // Floor from calibration averaging.
  input wire logic trim_changed, // Automatic logic changed an offset.
  input wire logic cal_complete, // Calibration sequence finished.
  output logic [FLOOR_W-1:0] prox_floor_value, // Stored proximity floor.
  output logic cal_irq_enable, // Calibration interrupt enable bit.
  output logic cal_irq // Calibration interrupt, active high.
);

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic wr_status;
  logic wr_clear;
  logic wr_enable;
  logic [3:0] w1c;
  logic cal_irq_clear;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [3:0] set_ev;
  logic irq_en_q;
  logic [csz_pkg::ZERO_CNT_W-1:0] zcnt_q;
  logic [csz_pkg::ZERO_CNT_W-1:0] zcnt_d;
  logic zero_hit_ev;
  logic floor_lower;
  logic floor_auto;
  logic [FLOOR_W-1:0] floor_q;

  assign wr_status = reg_wr && (reg_addr == csz_pkg::ADDR_CAL_STATUS);
  assign wr_clear = reg_wr && (reg_addr == csz_pkg::ADDR_IRQ_CLEAR);
  assign wr_enable = reg_wr && (reg_addr == csz_pkg::ADDR_IRQ_ENABLE);
  assign w1c = wr_status ? reg_wdata[3:0] : 4'h0; // R3 R11 R18
  assign cal_irq_clear = wr_clear && reg_wdata[csz_pkg::BIT_CAL_IRQ_CLR];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_q <= csz_pkg::RESET_IRQ_ENABLE[csz_pkg::BIT_CAL_IRQ_EN];
    end else if (wr_enable) begin
      irq_en_q <= reg_wdata[csz_pkg::BIT_CAL_IRQ_EN]; // R16
    end
  end

  // ---------------------------------------------------------------
  // Zero-hit counter
  // ---------------------------------------------------------------
  // Counter saturates at the limit so a burst of zeroes cannot wrap it.
  always_comb begin
    zcnt_d = zcnt_q;
    if (prox_cycle && zero_weight != 4'h0) begin
      if (|chan_zero) begin
        zcnt_d = zcnt_q + {1'b0, zero_weight}; // R15
        if (zcnt_d > csz_pkg::ZERO_CNT_LIMIT) begin
          zcnt_d = csz_pkg::ZERO_CNT_LIMIT;
        end
      end else if (zcnt_q != 5'h00) begin
        zcnt_d = zcnt_q - csz_pkg::ZERO_CNT_STEP_DOWN; // R15
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zcnt_q <= 5'h00;
    end else begin
      zcnt_q <= zcnt_d;
    end
  end

  // Flag pulses once when the counter first arrives at the limit.
  assign zero_hit_ev = (zero_weight != 4'h0) && (zcnt_d == csz_pkg::ZERO_CNT_LIMIT)
                       && (zcnt_q != csz_pkg::ZERO_CNT_LIMIT); // R1 R2 R14

  // ---------------------------------------------------------------
  // Proximity floor
  // ---------------------------------------------------------------
  assign floor_auto = avg_auto_floor || prox_avg_auto_floor;
  assign floor_lower = floor_sample_vld && floor_auto && (prox_floor_sample < floor_q);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      floor_q <= '1;
    end else if (cal_avg_done && avg_auto_floor) begin
      floor_q <= cal_floor_value; // R4
    end else if (floor_lower) begin
      floor_q <= prox_floor_sample; // R5
    end
  end
  assign prox_floor_value = floor_q;

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_comb begin
    set_ev = 4'h0;
    set_ev[csz_pkg::BIT_ZERO_HIT] = zero_hit_ev; // R1
    set_ev[csz_pkg::BIT_FLOOR_MOVED] = (cal_avg_done && avg_auto_floor) || floor_lower; // R4 R5 R6
    set_ev[csz_pkg::BIT_TRIM_MOVED] = trim_changed && (avg_auto_trim || prox_auto_trim); // R8 R9
    set_ev[csz_pkg::BIT_CAL_DONE] = cal_complete; // R10
    flags_d = flags_q & ~w1c; // R3 R11
    if (cal_irq_clear) begin
      flags_d[csz_pkg::BIT_FLOOR_MOVED] = 1'b0; // R7 R17
    end
    // A set arriving with a clear wins so no event is lost.
    flags_d = flags_d | set_ev;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= csz_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign cal_irq = irq_en_q && (|flags_q); // R12
  assign cal_irq_enable = irq_en_q;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        csz_pkg::ADDR_CAL_STATUS: reg_rdata <= {4'h0, flags_q}; // R18
        csz_pkg::ADDR_IRQ_ENABLE: reg_rdata <= {6'h00, irq_en_q, 1'b0};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Helper terms for the checks below. Five bits hold the worst case of 15 plus 15,
  // so the sum never wraps before it is compared with the limit.
  logic [csz_pkg::ZERO_CNT_W-1:0] zcnt_sum;
  logic zero_step;
  logic floor_cal_set;
  logic trim_set;

  assign zcnt_sum = zcnt_q + {1'b0, zero_weight};
  assign zero_step = prox_cycle && (zero_weight != 4'h0);
  assign floor_cal_set = cal_avg_done && avg_auto_floor;
  assign trim_set = trim_changed && (avg_auto_trim || prox_auto_trim);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_zero_clear;
    wr_status && reg_wdata[csz_pkg::BIT_ZERO_HIT] && !zero_hit_ev;
  endsequence

  sequence s_floor_clear;
    wr_status && reg_wdata[csz_pkg::BIT_FLOOR_MOVED] && !set_ev[csz_pkg::BIT_FLOOR_MOVED];
  endsequence

  sequence s_cnt_up;
    zero_step && (|chan_zero) && (zcnt_sum <= csz_pkg::ZERO_CNT_LIMIT);
  endsequence

  sequence s_cnt_clamp;
    zero_step && (|chan_zero) && (zcnt_sum > csz_pkg::ZERO_CNT_LIMIT);
  endsequence

  sequence s_cnt_down;
    zero_step && !(|chan_zero) && (zcnt_q != 5'h00);
  endsequence

  sequence s_done_with_irq;
    cal_complete && irq_en_q && !wr_enable;
  endsequence

  a_irq_follows_flags: assert property (s_done_with_irq |=> cal_irq) // R12
    else $error("calibration interrupt missing after calibration done");
  a_irq_gated_off: assert property (!irq_en_q |-> !cal_irq) // R16
    else $error("calibration interrupt raised while disabled");
  a_zero_weight_off: assert property ((zero_weight == 4'h0) && !flags_q[3] |=> !flags_q[3]) // R2
    else $error("zero-hit flag set with weight zero");
  a_zero_sets_flag: assert property (zero_hit_ev |=> flags_q[csz_pkg::BIT_ZERO_HIT]) // R1
    else $error("zero-hit flag not set at counter limit");
  a_zero_w1c: assert property (s_zero_clear |=> !flags_q[csz_pkg::BIT_ZERO_HIT]) // R3
    else $error("zero-hit flag not cleared by write one");
  a_zero_sticky: assert property (flags_q[3] && !(wr_status && reg_wdata[3]) |=> flags_q[3]) // R3
    else $error("zero-hit flag dropped without write one");
  a_floor_off: assert property (!floor_auto && !flags_q[2] |=> !flags_q[2]) // R6
    else $error("baseline-moved flag set with auto floor off");
  a_floor_irq_clear: assert property (cal_irq_clear && !set_ev[2] |=> !flags_q[2]) // R7 R17
    else $error("baseline-moved flag not cleared by interrupt clear");
  a_trim_off: assert property (!avg_auto_trim && !prox_auto_trim && !flags_q[1] // R9
                               |=> !flags_q[1])
    else $error("offset-moved flag set with auto trim off");
  a_done_sets: assert property (cal_complete |=> flags_q[csz_pkg::BIT_CAL_DONE]) // R10
    else $error("calibration-done flag not set");
  a_done_sticky: assert property (flags_q[0] && !(wr_status && reg_wdata[0]) |=> flags_q[0]) // R11
    else $error("calibration-done flag dropped without write one");
  a_lower_floor: assert property (floor_lower && !(cal_avg_done && avg_auto_floor) // R5
                                  |=> prox_floor_value == $past(prox_floor_sample))
    else $error("lower floor sample not stored");
  a_cnt_bound: assert property (zcnt_q <= csz_pkg::ZERO_CNT_LIMIT) // R14
    else $error("zero counter exceeded its limit");
  a_rsvd_zero: assert property (reg_rd && reg_addr == csz_pkg::ADDR_CAL_STATUS // R18
                                |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved status bits read non-zero");
  a_rd_status: assert property (reg_rd && reg_addr == csz_pkg::ADDR_CAL_STATUS // R18
    |=> reg_rdata[3:0] == $past(flags_q))
    else $error("status read does not return the flags");

  // The upward step is checked against the helper sum, not the next-state logic.
  a_cnt_step_up: assert property (s_cnt_up |=> zcnt_q == $past(zcnt_sum)) // R15
    else $error("zero counter did not add the weight");
  a_cnt_step_down: assert property (s_cnt_down // R15
    |=> zcnt_q == $past(zcnt_q) - csz_pkg::ZERO_CNT_STEP_DOWN)
    else $error("zero counter did not step down");
  a_cnt_clamp: assert property (s_cnt_clamp |=> zcnt_q == csz_pkg::ZERO_CNT_LIMIT) // R14
    else $error("zero counter did not saturate");
  a_cnt_frozen: assert property (zero_weight == 4'h0 |=> $stable(zcnt_q)) // R2
    else $error("zero counter moved with weight zero");
  a_cnt_idle: assert property (!prox_cycle |=> $stable(zcnt_q)) // R15
    else $error("zero counter moved outside a cycle");

  a_floor_cal_sets: assert property (floor_cal_set // R4
    |=> flags_q[csz_pkg::BIT_FLOOR_MOVED] && prox_floor_value == $past(cal_floor_value))
    else $error("calibration floor not loaded or flagged");
  a_floor_lower_sets: assert property (floor_lower |=> flags_q[csz_pkg::BIT_FLOOR_MOVED]) // R5
    else $error("baseline-moved flag not set by lower sample");
  a_floor_w1c: assert property (s_floor_clear |=> !flags_q[csz_pkg::BIT_FLOOR_MOVED]) // R7
    else $error("baseline-moved flag not cleared by write one");
  a_floor_sticky: assert property (flags_q[2] && !cal_irq_clear // R7
    && !(wr_status && reg_wdata[2]) |=> flags_q[2])
    else $error("baseline-moved flag dropped without a clear");

  a_trim_sets: assert property (trim_set |=> flags_q[csz_pkg::BIT_TRIM_MOVED]) // R8
    else $error("offset-moved flag not set");
  a_trim_w1c: assert property (wr_status && reg_wdata[1] && !trim_set // R11
    |=> !flags_q[1])
    else $error("offset-moved flag not cleared by write one");
  a_trim_sticky: assert property (flags_q[1] && !(wr_status && reg_wdata[1]) // R11
    |=> flags_q[1])
    else $error("offset-moved flag dropped without write one");
  a_done_w1c: assert property (wr_status && reg_wdata[0] && !cal_complete // R11
    |=> !flags_q[0])
    else $error("calibration-done flag not cleared by write one");

  // The enable changes only through its own register write.
  a_en_set: assert property (wr_enable && reg_wdata[csz_pkg::BIT_CAL_IRQ_EN] // R16
    |=> cal_irq_enable)
    else $error("calibration interrupt enable not set");
  a_en_clear: assert property (wr_enable && !reg_wdata[csz_pkg::BIT_CAL_IRQ_EN] // R16
    |=> !cal_irq_enable)
    else $error("calibration interrupt enable not cleared");
  a_en_hold: assert property (!wr_enable |=> $stable(cal_irq_enable)) // R16
    else $error("calibration interrupt enable changed without a write");

endmodule

// >>> test/csz_calib_status_tb.sv
// Self-checking testbench for the calibration status flag bank.
`timescale 1ns/1ps

module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic prox_cycle = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] zero_weight = 4'h0;
  logic [3:0] chan_zero = 4'h0;
  logic [3:0] ctrl = 4'h0;
  logic [3:0] evs = 4'h0;
  logic [15:0] fs = 16'hFFFF;
  logic [15:0] cfv = 16'h1234;
  logic [15:0] exp_floor = 16'hFFFF;
  logic [7:0] reg_rdata;
  logic [15:0] prox_floor_value;
  logic cal_irq_enable;
  logic cal_irq;
  int error_cnt = 0;
  int cmp_count = 0;
  // ---------------------------------------------------------------
  // Rows: auto controls, event kind, expected status low nibble.
  // ---------------------------------------------------------------
  logic [9:0] rows [9] = '{10'b0000_00_0001, 10'b0000_01_0000, 10'b0010_01_0010,
    10'b0001_01_0010, 10'b1000_10_0100, 10'b0000_10_0000, 10'b0100_11_0100,
    10'b1000_11_0100, 10'b0000_11_0000};

  always #2.5 clk = ~clk;

  csz_calib_status u_csz_calib_status (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .zero_weight(zero_weight), .prox_cycle(prox_cycle), .chan_zero(chan_zero),
    .avg_auto_floor(ctrl[3]), .prox_avg_auto_floor(ctrl[2]), .avg_auto_trim(ctrl[1]),
    .prox_auto_trim(ctrl[0]), .cal_avg_done(evs[2]), .floor_sample_vld(evs[3]),
    .prox_floor_sample(fs), .cal_floor_value(cfv), .trim_changed(evs[1]),
    .cal_complete(evs[0]), .prox_floor_value(prox_floor_value),
    .cal_irq_enable(cal_irq_enable), .cal_irq(cal_irq));

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    chk({8'h00, reg_rdata}, {8'h00, exp});
    tick();
  endtask

  task automatic pulse(input int k);
    evs = 4'h1 << k;
    tick();
    evs = 4'h0;
    tick();
  endtask

  task automatic cycle(input logic [3:0] z);
    chan_zero = z;
    prox_cycle = 1'b1;
    tick();
    prox_cycle = 1'b0;
    tick();
  endtask

  initial begin
    #50000;
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h00);
    chk(prox_floor_value, 16'hFFFF);
    chk({15'h0, cal_irq_enable | cal_irq}, 16'h0000);
    rd(8'h00, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      ctrl = rows[i][9:6];
      fs = exp_floor - 16'h0001;
      pulse(int'(rows[i][5:4]));
      if (rows[i][5:4] == 2'd2 && ctrl[3]) exp_floor = cfv;
      if (rows[i][5:4] == 2'd3 && rows[i][3:0] != 4'h0) exp_floor = fs;
      rd(csz_pkg::ADDR_CAL_STATUS, {4'h0, rows[i][3:0]});
      chk(prox_floor_value, exp_floor);
      ctrl = 4'h0;
      wr(csz_pkg::ADDR_CAL_STATUS, 8'h0F);
      rd(csz_pkg::ADDR_CAL_STATUS, 8'h00);
    end
    $display("test table done");
    repeat (20) cycle(4'hF);
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h00);
    zero_weight = 4'h4;
    cycle(4'h1);
    cycle(4'h8);
    cycle(4'h0);
    cycle(4'h2);
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h00);
    cycle(4'h4);
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h08);
    pulse(0);
    wr(csz_pkg::ADDR_CAL_STATUS, 8'hF7);
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h08);
    wr(csz_pkg::ADDR_CAL_STATUS, 8'h08);
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h00);
    cycle(4'hF);
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h00);
    cycle(4'h0);
    cycle(4'hF);
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h08);
    wr(csz_pkg::ADDR_CAL_STATUS, 8'h08);
    zero_weight = 4'h0;
    $display("test zero detect done");
    wr(csz_pkg::ADDR_IRQ_ENABLE, 8'h02);
    chk({14'h0, cal_irq_enable, cal_irq}, 16'h0002);
    rd(csz_pkg::ADDR_IRQ_ENABLE, 8'h02);
    pulse(0);
    chk({15'h0, cal_irq}, 16'h0001);
    wr(csz_pkg::ADDR_IRQ_CLEAR, 8'h02);
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h01);
    ctrl = 4'h8;
    pulse(2);
    ctrl = 4'h0;
    wr(csz_pkg::ADDR_CAL_STATUS, 8'h01);
    chk({15'h0, cal_irq}, 16'h0001);
    wr(csz_pkg::ADDR_IRQ_CLEAR, 8'h02);
    chk({15'h0, cal_irq}, 16'h0000);
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h00);
    pulse(0);
    wr(csz_pkg::ADDR_IRQ_ENABLE, 8'hFD);
    chk({14'h0, cal_irq_enable, cal_irq}, 16'h0000);
    $display("test interrupt done");
    reg_addr = csz_pkg::ADDR_CAL_STATUS;
    reg_wdata = 8'h01;
    reg_wr = 1'b1;
    evs = 4'h1;
    tick();
    reg_wr = 1'b0;
    evs = 4'h0;
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h01);
    $display("test set over clear done");
    wr(csz_pkg::ADDR_IRQ_ENABLE, 8'h02);
    chk({15'h0, cal_irq}, 16'h0001);
    sys_rst = 1'b1;
    tick();
    chk({14'h0, cal_irq_enable, cal_irq}, 16'h0000);
    chk({8'h00, reg_rdata}, 16'h0000);
    chk(prox_floor_value, 16'hFFFF);
    sys_rst = 1'b0;
    rd(csz_pkg::ADDR_CAL_STATUS, 8'h00);
    rd(csz_pkg::ADDR_IRQ_ENABLE, 8'h00);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
